// >>> rtl/biphase_rx_output_error_mux.sv
//
// Contract
// - Select low shows error code on outputs; select high shows data byte.
// - Outputs float while output enable is low, driven while high.
// - Bus is ten bits; seven positions carry error bits in code mode.
// - Bit 2 flags overflow: new byte with holding and shift both full.
// - Bit 3 flags odd parity over received data and sync bits.
// - Bit 4 is set whenever bit 3, 5 or 6 is set.
// - Bit 5 flags an invalid ending sequence.
// - Bit 6 flags a lost mid-bit transition outside the ending sequence.
// - Bit 7 flags a new start while holding register is unread.
// - Bit 8 flags line disabled while a message is being received.
// - Receive-active rises 3.5 clock periods plus 70 ns after start.
// - First byte-available rises 92 clock periods after receive-active rises.
// - Receive-active falls 11.5 clock periods plus 50 ns after ending edge.
// - Error flag clears on error-code read or on the next start.
// - Any error raises error flag and drops receive-active and byte-available.
// - Held data stays while read low; on release, waiting byte moves up.
`timescale 1ns/10ps
`default_nettype none
module biphase_rx_output_error_mux #(
  parameter int BUS_W       = biphase_rx_pkg::BUS_W,
  parameter int ON_CYCLES   = biphase_rx_pkg::ON_CYCLES,
  parameter int GATE_CYCLES = biphase_rx_pkg::GATE_CYCLES,
  parameter int OFF_CYCLES  = biphase_rx_pkg::OFF_CYCLES
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire biphase_rx_pkg::line_events_s line_ev,
  input  wire logic                         byte_valid,
  input  wire logic [BUS_W-1:0]             byte_in,
  input  wire logic                         rx_disable,
  input  wire logic                         out_sel,
  input  wire logic                         out_en,
  input  wire logic                         reg_read_n,
  output logic                              rx_active,
  output logic                              rx_error,
  output logic                              byte_avail,
  output logic [BUS_W-1:0]                  data_out,
  output logic [BUS_W-1:0]                  data_oe
);

  biphase_rx_pkg::rx_state_s s;
  biphase_rx_pkg::rx_state_s next_s;
  biphase_rx_pkg::err_code_s err_new;

  logic in_msg;
  logic start_ok;
  logic start_go;
  logic off_go;
  logic read_rise;
  logic err_read;
  logic data_read;
  logic overflow;
  logic any_err;
  logic on_done;
  logic gate_done;
  logic off_done;

  // Strobe decode; the release edge of the read strobe completes a read
  assign in_msg    = (s.phase != biphase_rx_pkg::PH_IDLE);
  assign start_ok  = line_ev.start_seen && !rx_disable;
  assign read_rise = !s.read_n_prev && reg_read_n;
  assign err_read  = read_rise && !out_sel;
  assign data_read = read_rise && out_sel;
  assign overflow  = (s.phase == biphase_rx_pkg::PH_ACTIVE) && byte_valid
                     && s.hold_full && s.shift_full;

  // Error causes found this cycle
  always_comb begin
    err_new = '0;
    err_new.err_overflow_bit        = overflow;
    err_new.err_parity_bit          = in_msg && line_ev.parity_err;
    err_new.err_bad_ending_bit      = in_msg && line_ev.bad_ending;
    err_new.err_lost_midbit_bit     = in_msg && line_ev.lost_midbit;
    err_new.err_early_start_bit     = start_ok && s.hold_full;
    err_new.err_disabled_active_bit = in_msg && rx_disable;
    err_new.err_transmit_check_bit  = err_new.err_parity_bit
                                      || err_new.err_bad_ending_bit
                                      || err_new.err_lost_midbit_bit;
  end

  assign any_err  = |err_new;
  assign start_go = start_ok && !in_msg && !any_err;
  assign off_go   = (s.phase == biphase_rx_pkg::PH_ACTIVE) && line_ev.end_seen && !any_err;

  // Start latency timer
  delay_timer #(.COUNT(ON_CYCLES)) on_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (start_go),
    .abort   (any_err),
    .done    (on_done)
  );

  // Holds back the first byte-available after receive-active rises
  delay_timer #(.COUNT(GATE_CYCLES)) gate_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (on_done),
    .abort   (any_err || start_go),
    .done    (gate_done)
  );

  // End latency timer
  delay_timer #(.COUNT(OFF_CYCLES)) off_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (off_go),
    .abort   (any_err),
    .done    (off_done)
  );

  // Next state; clears are applied before sets so a same-cycle event is kept
  always_comb begin
    next_s             = s;
    next_s.read_n_prev = reg_read_n;

    // Data read done: hold frees, a waiting byte moves up one cycle later
    if (data_read) begin
      next_s.hold_full = 1'b0;
      next_s.move_pend = s.shift_full;
    end
    if (s.move_pend) begin
      next_s.hold_data  = s.shift_data;
      next_s.hold_full  = 1'b1;
      next_s.shift_full = 1'b0;
      next_s.move_pend  = 1'b0;
    end

    // New byte from the shift path; overflow is handled as an error
    if (byte_valid && (s.phase == biphase_rx_pkg::PH_ACTIVE) && !overflow) begin
      if (next_s.hold_full || next_s.move_pend) begin
        next_s.shift_data = byte_in;
        next_s.shift_full = 1'b1;
      end else begin
        next_s.hold_data = byte_in;
        next_s.hold_full = 1'b1;
      end
    end

    // Message phase sequencing
    unique case (s.phase)
      biphase_rx_pkg::PH_IDLE: begin
        if (start_go) begin
          next_s.phase      = biphase_rx_pkg::PH_STARTING;
          next_s.gate_open  = 1'b0;
          next_s.shift_full = 1'b0;
        end
      end
      biphase_rx_pkg::PH_STARTING: begin
        if (on_done) begin
          next_s.phase = biphase_rx_pkg::PH_ACTIVE;
        end
      end
      biphase_rx_pkg::PH_ACTIVE: begin
        if (off_go) begin
          next_s.phase = biphase_rx_pkg::PH_ENDING;
        end
      end
      biphase_rx_pkg::PH_ENDING: begin
        if (off_done) begin
          next_s.phase = biphase_rx_pkg::PH_IDLE;
        end
      end
    endcase

    if (gate_done) begin
      next_s.gate_open = 1'b1;
    end

    // Error read or a fresh start clears the flag and its code
    if (err_read || start_ok) begin
      next_s.err_flag = 1'b0;
      next_s.code     = '0;
    end

    // Any error ends the message at once; set wins over the clear above
    if (any_err) begin
      next_s.err_flag   = 1'b1;
      next_s.code       = next_s.code | err_new;
      next_s.phase      = biphase_rx_pkg::PH_IDLE;
      next_s.hold_full  = 1'b0;
      next_s.shift_full = 1'b0;
      next_s.move_pend  = 1'b0;
    end

    // Registered bus word; unused positions forced low in code mode
    if (out_sel) begin
      next_s.bus_q = s.hold_data;
    end else begin
      next_s.bus_q = {1'b0, s.code, 2'b00};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s             <= '0;
      s.phase       <= biphase_rx_pkg::PH_IDLE;
      s.read_n_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs; enable is combinational so the bus floats without a cycle lag
  assign rx_active  = (s.phase == biphase_rx_pkg::PH_ACTIVE)
                      || (s.phase == biphase_rx_pkg::PH_ENDING);
  assign rx_error   = s.err_flag;
  assign byte_avail = s.hold_full && s.gate_open;
  assign data_out   = s.bus_q;
  assign data_oe    = {BUS_W{out_en}};

  // Cycles since receive-active rose, saturating, for checking only
  logic [7:0] act_age;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !rx_active) begin
      act_age <= 8'h00;
    end else if (act_age != 8'hff) begin
      act_age <= act_age + 8'h01;
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  localparam int GATE_A = GATE_CYCLES;

  code_mux_a: assert property (!$past(out_sel)
      |-> data_out == {1'b0, $past(s.code), 2'b00})
    else $error("error code not shown with select low");

  data_mux_a: assert property ($past(out_sel) |-> data_out == $past(s.hold_data))
    else $error("data byte not shown with select high");

  bus_drive_a: assert property (data_oe == (out_en ? 10'h3ff : 10'h000))
    else $error("output enable does not match bus drive");

  unused_low_a: assert property (!$past(out_sel)
      |-> (data_out[1:0] == 2'b00) && !data_out[9])
    else $error("unused bus bits not low in code mode");

  xmit_sum_a: assert property (s.code.err_transmit_check_bit ==
      (s.code.err_parity_bit || s.code.err_bad_ending_bit || s.code.err_lost_midbit_bit))
    else $error("transmit check bit does not summarise");

  overflow_bit_a: assert property (overflow |=> rx_error
      && s.code.err_overflow_bit && !rx_active)
    else $error("overflow not flagged");

  parity_bit_a: assert property (in_msg && line_ev.parity_err
      |=> s.code.err_parity_bit && s.code.err_transmit_check_bit)
    else $error("parity error not flagged");

  bad_end_a: assert property (in_msg && line_ev.bad_ending
      |=> s.code.err_bad_ending_bit)
    else $error("bad ending not flagged");

  lost_mid_a: assert property (in_msg && line_ev.lost_midbit
      |=> s.code.err_lost_midbit_bit)
    else $error("lost mid-bit not flagged");

  early_start_a: assert property (start_ok && s.hold_full
      |=> s.code.err_early_start_bit && !byte_avail)
    else $error("early start not flagged");

  disable_bit_a: assert property (in_msg && rx_disable
      |=> s.code.err_disabled_active_bit && !rx_active)
    else $error("disable during message not flagged");

  rise_delay_a: assert property (start_go
      |-> ##ON_CYCLES !rx_active ##1 (rx_active || rx_error))
    else $error("receive-active rise latency wrong");

  first_avail_a: assert property (byte_avail && rx_active
      |-> act_age >= 8'(GATE_A))
    else $error("byte available before gate time");

  fall_delay_a: assert property (off_go
      |-> ##OFF_CYCLES (rx_active || rx_error) ##1 !rx_active)
    else $error("receive-active fall latency wrong");

  err_clear_a: assert property (err_read && !any_err |=> !rx_error)
    else $error("error flag not cleared by code read");

  terminate_a: assert property (any_err
      |=> rx_error && !rx_active && !byte_avail)
    else $error("error did not terminate message");

  move_up_a: assert property (data_read && s.shift_full && !any_err
      |=> !s.hold_full ##1 s.hold_full)
    else $error("waiting byte not moved after read");

  msg_done_c: cover property (off_go ##OFF_CYCLES rx_active ##1 !rx_active && !rx_error);
  err_read_c: cover property (rx_error ##[1:20] err_read);
  overflow_c: cover property (overflow);
  move_up_c: cover property (data_read && s.shift_full);

endmodule // biphase_rx_output_error_mux
`default_nettype wire

// >>> pkg/biphase_rx_pkg.sv
`default_nettype none
package biphase_rx_pkg;

  // Bus geometry and error code placement
  localparam int BUS_W          = 10;
  localparam int ERR_W          = 7;
  localparam int ERR_LSB        = 2;
  localparam int ERR_OVERFLOW   = 2;
  localparam int ERR_PARITY     = 3;
  localparam int ERR_XMIT_CHECK = 4;
  localparam int ERR_BAD_ENDING = 5;
  localparam int ERR_LOST_MID   = 6;
  localparam int ERR_EARLY      = 7;
  localparam int ERR_DISABLED   = 8;

  // Receiver clock period; T in the latency figures is this period
  localparam int CLK_PERIOD_NS  = 10;

  // Start latency: 3.5 T plus a fixed 70 ns, least time so rounded up
  localparam int ON_T_X10       = 35;
  localparam int ON_FIXED_NS    = 70;
  localparam int ON_DELAY_NS    = ON_T_X10 * CLK_PERIOD_NS / 10 + ON_FIXED_NS;
  localparam int ON_CYCLES      = (ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // First byte available: 92 T after receive-active rises
  localparam int GATE_T         = 92;
  localparam int GATE_NS        = GATE_T * CLK_PERIOD_NS;
  localparam int GATE_CYCLES    = (GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // End latency: 11.5 T plus a fixed 50 ns
  localparam int OFF_T_X10      = 115;
  localparam int OFF_FIXED_NS   = 50;
  localparam int OFF_DELAY_NS   = OFF_T_X10 * CLK_PERIOD_NS / 10 + OFF_FIXED_NS;
  localparam int OFF_CYCLES     = (OFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W        = 8;

  typedef enum logic [1:0] {PH_IDLE, PH_STARTING, PH_ACTIVE, PH_ENDING} phase_e;

  // Error code, most significant field lands on bus bit 8
  typedef struct packed {
    logic err_disabled_active_bit;
    logic err_early_start_bit;
    logic err_lost_midbit_bit;
    logic err_bad_ending_bit;
    logic err_transmit_check_bit;
    logic err_parity_bit;
    logic err_overflow_bit;
  } err_code_s;

  // One-cycle event pulses from the demodulator
  typedef struct packed {
    logic start_seen;
    logic end_seen;
    logic parity_err;
    logic bad_ending;
    logic lost_midbit;
  } line_events_s;

  typedef struct packed {
    logic               busy;
    logic [TIMER_W-1:0] count;
  } timer_s;

  typedef struct packed {
    phase_e             phase;
    logic               err_flag;
    err_code_s          code;
    logic               hold_full;
    logic               shift_full;
    logic               move_pend;
    logic               gate_open;
    logic               read_n_prev;
    logic [BUS_W-1:0]   hold_data;
    logic [BUS_W-1:0]   shift_data;
    logic [BUS_W-1:0]   bus_q;
  } rx_state_s;

endpackage
`default_nettype wire

// >>> rtl/delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module delay_timer #(
  parameter int COUNT = 2
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);

  biphase_rx_pkg::timer_s s;
  biphase_rx_pkg::timer_s next_s;

  // Load COUNT so the consumer acts on the edge exactly COUNT cycles after start
  always_comb begin
    next_s = s;
    if (abort) begin
      next_s.busy = 1'b0;
    end else if (start) begin
      next_s.busy  = 1'b1;
      next_s.count = biphase_rx_pkg::TIMER_W'(COUNT);
    end else if (s.busy) begin
      if (s.count == biphase_rx_pkg::TIMER_W'(1)) begin
        next_s.busy = 1'b0;
      end
      next_s.count = s.count - biphase_rx_pkg::TIMER_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.busy && (s.count == biphase_rx_pkg::TIMER_W'(1)) && !abort;

endmodule // delay_timer
`default_nettype wire

// >>> verif/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host logic on the parallel side: one strobed read per request
module host_bus_model (
  input  wire logic                             ref_clk,
  input  wire logic                             reset_n,
  input  wire logic                             req,
  input  wire logic                             req_sel,
  input  wire logic [biphase_rx_pkg::BUS_W-1:0] data_out,
  input  wire logic [biphase_rx_pkg::BUS_W-1:0] data_oe,
  output logic                                  out_sel,
  output logic                                  out_en,
  output logic                                  reg_read_n,
  output logic                                  done,
  output logic [biphase_rx_pkg::BUS_W-1:0]      bus_seen
);
  logic [1:0]                       step;
  logic [biphase_rx_pkg::BUS_W-1:0] last;
  logic [biphase_rx_pkg::BUS_W-1:0] bus;

  // Undriven bits show the inverse of their last level, so a float never reads as a match
  assign bus = (data_oe & data_out) | (~data_oe & ~last);

  // Select and enable stand past strobe release to honour the hold time
  always_ff @(posedge ref_clk) begin
    last <= reset_n ? bus : '0;
    done <= 1'b0;
    if (!reset_n) begin
      step       <= 2'h0;
      out_sel    <= 1'b1;
      out_en     <= 1'b0;
      reg_read_n <= 1'b1;
    end else begin
      case (step)
        2'h0: if (req) begin
          out_sel    <= req_sel;
          out_en     <= 1'b1;
          reg_read_n <= 1'b0;
          step       <= 2'h1;
        end
        2'h1: step <= 2'h2;
        2'h2: begin
          bus_seen   <= bus;
          reg_read_n <= 1'b1;
          step       <= 2'h3;
        end
        default: begin
          out_en <= 1'b0;
          done   <= 1'b1;
          step   <= 2'h0;
        end
      endcase
    end
  end
endmodule // host_bus_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int W = biphase_rx_pkg::BUS_W;
  localparam int G = biphase_rx_pkg::GATE_CYCLES;
  logic                         ref_clk, reset_n, byte_valid, rx_disable, req, req_sel;
  logic                         out_sel, out_en, reg_read_n, done;
  logic                         rx_active, rx_error, byte_avail;
  biphase_rx_pkg::line_events_s line_ev, ev;
  logic [W-1:0]                 byte_in, data_out, data_oe, bus_seen;
  logic [W-1:0]                 codes [6];
  int                           fail_count, num_checks, t, t0, ta, k;
  int                           cycles = 0;

  biphase_rx_output_error_mux uut (.ref_clk(ref_clk), .reset_n(reset_n), .line_ev(line_ev),
    .byte_valid(byte_valid), .byte_in(byte_in), .rx_disable(rx_disable), .out_sel(out_sel),
    .out_en(out_en), .reg_read_n(reg_read_n), .rx_active(rx_active), .rx_error(rx_error),
    .byte_avail(byte_avail), .data_out(data_out), .data_oe(data_oe));
  host_bus_model host (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .req_sel(req_sel),
    .data_out(data_out), .data_oe(data_oe), .out_sel(out_sel), .out_en(out_en),
    .reg_read_n(reg_read_n), .done(done), .bus_seen(bus_seen));

  // Receiver clock is the eight-times bit clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Cycle stamp doubles as the hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [W-1:0] exp, input logic [W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Tasks start by waiting an edge and return settled just after one
  task automatic pulse(input biphase_rx_pkg::line_events_s e);
    @(posedge ref_clk);
    line_ev <= e;
    @(posedge ref_clk);
    line_ev <= '0;
    #1;
  endtask

  task automatic send_byte(input logic [W-1:0] b);
    @(posedge ref_clk);
    byte_valid <= 1'b1;
    byte_in    <= b;
    @(posedge ref_clk);
    byte_valid <= 1'b0;
    #1;
  endtask

  // Bounded wait on rx_active (0), byte_avail (1) or host done (2)
  task automatic wait_sig(input int s, input logic lvl, output int ts);
    int n;
    n = 0;
    while ((s == 0 ? rx_active : s == 1 ? byte_avail : done) !== lvl && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A wait that runs out is a mismatch, never a silent pass
    if (n == 200) begin
      fail_count++;
      $display("wrong value wait_sig %0d expected %b seen %b", s, lvl, !lvl);
    end
    ts = cycles;
  endtask

  task automatic start_msg;
    ev = '0;
    ev.start_seen = 1'b1;
    pulse(ev);
    t0 = cycles;
    wait_sig(0, 1'b1, ta);
    check("rx_active rise", W'(biphase_rx_pkg::ON_CYCLES), W'(ta - t0));
  endtask

  task automatic host_read(input logic sel);
    @(posedge ref_clk);
    req     <= 1'b1;
    req_sel <= sel;
    @(posedge ref_clk);
    req <= 1'b0;
    wait_sig(2, 1'b1, t);
    check("data_oe off", '0, data_oe);
    @(posedge ref_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence: clean message, then every error cause, then clear by start
  initial begin
    reset_n = 1'b0; line_ev = '0; byte_valid = 1'b0; byte_in = '0;
    rx_disable = 1'b0; req = 1'b0; req_sel = 1'b1; fail_count = 0; num_checks = 0;
    codes = '{10'h018, 10'h030, 10'h050, 10'h100, 10'h004, 10'h080};
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    check("reset rx_active", '0, W'(rx_active));
    check("reset rx_error", '0, W'(rx_error));
    check("reset byte_avail", '0, W'(byte_avail));
    check("reset data_oe", '0, data_oe);
    start_msg();
    send_byte(10'h2a5);
    wait_sig(1, 1'b1, t);
    check("gate delay", W'(G), W'(t - ta));
    host_read(1'b1);
    check("data A", 10'h2a5, bus_seen);
    check("avail after read", '0, W'(byte_avail));
    send_byte(10'h15a);
    send_byte(10'h3c3);
    host_read(1'b1);
    check("data B", 10'h15a, bus_seen);
    wait_sig(1, 1'b1, t);
    check("waiting byte moved", W'(1), W'(byte_avail));
    host_read(1'b1);
    check("data C", 10'h3c3, bus_seen);
    host_read(1'b0);
    check("clean code", '0, bus_seen);
    ev = '0;
    ev.end_seen = 1'b1;
    pulse(ev);
    t0 = cycles;
    wait_sig(0, 1'b0, t);
    check("rx_active fall", W'(biphase_rx_pkg::OFF_CYCLES), W'(t - t0));
    for (k = 0; k < 6; k++) begin
      start_msg();
      ev = '0;
      case (k)
        0: ev.parity_err = 1'b1;
        1: ev.bad_ending = 1'b1;
        2: ev.lost_midbit = 1'b1;
        default: ev = '0;
      endcase
      if (k < 3) begin
        pulse(ev);
      end else if (k == 3) begin
        @(posedge ref_clk);
        rx_disable <= 1'b1;
        @(posedge ref_clk);
        #1;
      end else begin
        send_byte(10'h001);
        if (k == 4) begin
          send_byte(10'h002);
          send_byte(10'h003);
        end else begin
          ev.start_seen = 1'b1;
          pulse(ev);
        end
      end
      check("error raised", W'(1), W'(rx_error));
      check("active dropped", '0, W'(rx_active));
      check("avail dropped", '0, W'(byte_avail));
      @(posedge ref_clk);
      rx_disable <= 1'b0;
      host_read(1'b0);
      check("error code", codes[k], bus_seen);
      check("error cleared by read", '0, W'(rx_error));
    end
    start_msg();
    ev = '0;
    ev.parity_err = 1'b1;
    pulse(ev);
    start_msg();
    check("error cleared by start", '0, W'(rx_error));
    end_of_test();
  end
endmodule // tb
`default_nettype wire
